// File: hw/eba_master.v
`include "eba_defs.vh"
module eba_master (
  input wire mclk_i,
  input wire rst_i,
  input wire req_valid_i,
  output wire req_ready_o,
  input wire [31:0] req_addr_i,
  input wire req_read_i,
  input wire req_burst_i,
  input wire [1:0] req_size_i,
  input wire req_port16_i,
  input wire req_stcx_i,
  input wire parked_i,
  output reg stcx_fail_o,
  input wire bus_grant_n_i,
  input wire bus_busy_n_i,
  input wire cancel_reservation_n_i,
  input wire address_ack_n_i,
  input wire int_address_ack_i,
  input wire address_retry_n_i,
  input wire transfer_error_ack_n_i,
  input wire data_done_i,
  input wire burst_inhibit_n_i,
  output wire bus_request_n_o,
  output reg bus_busy_n_o,
  output reg bus_busy_oe_n_o,
  output reg transfer_start_n_o,
  output reg [`EBA_ADDR_W-1:0] addr_o,
  output reg write_read_o,
  output reg burst_n_o,
  output reg [`EBA_BE_W-1:0] byte_lane_enable_n_o,
  output reg attr_oe_n_o,
  output reg addr_done_o
);
  reg [1:0] st_q;
  reg half_q;
  reg split_q;
  reg inh_q;
  wire qual;
  wire [`EBA_BE_W-1:0] lanes;
  // internal ack ORed, never driven out
  wire ack = !address_ack_n_i || int_address_ack_i;
  wire retry = !address_retry_n_i;
  wire terr = !transfer_error_ack_n_i;
  wire tenure = (st_q == `EBA_ST_ADDR);
  wire own = (st_q == `EBA_ST_DATA) && !bus_busy_oe_n_o;
  // store-conditional with cancel is not issued
  wire cancel = req_stcx_i && !cancel_reservation_n_i;
  wire start_ok = (st_q == `EBA_ST_IDLE || st_q == `EBA_ST_DATA
                   || st_q == `EBA_ST_REL);
  wire start = start_ok && req_valid_i && !cancel && qual && !split_q;
  assign req_ready_o = start || (start_ok && req_valid_i && qual && cancel);
  eba_arb u_arb (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .need_i(req_valid_i || split_q),
    .parked_i(parked_i),
    .bus_grant_n_i(bus_grant_n_i),
    .bus_busy_n_i(bus_busy_n_i),
    .own_busy_i(own),
    .tenure_i(tenure),
    .starting_i(start),
    .qual_o(qual),
    .bus_request_n_o(bus_request_n_o)
  );
  eba_lane u_lane (
    .port16_i(req_port16_i),
    .low_addr_i(req_addr_i[1:0]),
    .size_i(req_size_i),
    .lane_n_o(lanes)
  );
  always @(posedge mclk_i) begin
    if (rst_i) begin
      st_q <= `EBA_ST_IDLE;
      half_q <= 1'b0;
      split_q <= 1'b0;
      inh_q <= 1'b0;
      stcx_fail_o <= 1'b0;
      bus_busy_n_o <= 1'b1;
      bus_busy_oe_n_o <= 1'b1;
      transfer_start_n_o <= 1'b1;
      addr_o <= {`EBA_ADDR_W{1'b0}};
      write_read_o <= 1'b1;
      burst_n_o <= 1'b1;
      byte_lane_enable_n_o <= {`EBA_BE_W{1'b1}};
      attr_oe_n_o <= 1'b1;
      addr_done_o <= 1'b0;
    end else begin
      transfer_start_n_o <= 1'b1;
      addr_done_o <= 1'b0;
      stcx_fail_o <= req_ready_o && cancel;
      half_q <= 1'b0;
      if (start) begin
        // one-clock start with busy, drive address and attributes
        transfer_start_n_o <= 1'b0;
        bus_busy_n_o <= 1'b0;
        bus_busy_oe_n_o <= 1'b0;
        attr_oe_n_o <= 1'b0;
        addr_o <= req_addr_i[31:2];
        write_read_o <= req_read_i;
        burst_n_o <= !(req_burst_i || inh_q);
        byte_lane_enable_n_o <= lanes;
        split_q <= req_port16_i && !req_burst_i && (req_size_i == `EBA_SZ_WORD);
        st_q <= `EBA_ST_ADDR;
      end else begin
        case (st_q)
          `EBA_ST_ADDR: begin
            // hold attributes until ack, retry/error also end phase
            if (retry || terr) begin
              st_q <= `EBA_ST_REL;
              bus_busy_n_o <= 1'b1;
              half_q <= 1'b1;
            end else if (ack) begin
              addr_done_o <= 1'b1;
              inh_q <= !burst_inhibit_n_i && !burst_n_o;
              // pipelining: next start allowed in data state
              st_q <= `EBA_ST_DATA;
            end
          end
          `EBA_ST_DATA: begin
            if (data_done_i || terr) begin
              if (split_q) begin
                split_q <= 1'b0;
                // second half differs only in the lane-two address bit
                byte_lane_enable_n_o[`EBA_LANE_A30] <= 1'b1;
                transfer_start_n_o <= 1'b0;
                st_q <= `EBA_ST_ADDR;
              end else begin
                bus_busy_n_o <= 1'b1;
                half_q <= 1'b1;
                st_q <= `EBA_ST_REL;
                if (burst_n_o) inh_q <= 1'b0;
              end
            end
          end
          `EBA_ST_REL: begin
            if (!half_q) begin
              bus_busy_oe_n_o <= 1'b1;
              attr_oe_n_o <= 1'b1;
              st_q <= `EBA_ST_IDLE;
            end
          end
          default: st_q <= `EBA_ST_IDLE;
        endcase
      end
    end
  end
endmodule

// File: hw/eba_defs.vh
// Notes on behaviour
// - Request bus when unparked, needed, ungranted, not starting
// - Take mastership only on qualified grant
// - No start while other master holds busy, unless grant was qualified last cycle
// - Drop request when own cycle starts
// - Requalify grant only at tenure completion
// - Ignore grant between start and address ack
// - Grant qualified last cycle still valid
// - Assert busy per cycle, hold across halves
// - Drive busy negated half clock, then release (code drives it negated two clocks)
// - Cancel reservation suppresses store-conditional cycles
// - Start strobe one clock, phase until ack
// - Drive address after grant, release when idle
// - Word address; lane two carries address bit on 16-bit port
// - Write/read high for read, held per phase
// - Burst attribute kept on inhibited decomposed beats
// - Lane enables per port width and size
// - Early address ack allows pipelined next phase
// - OR internal ack with external pin
// - Hold address and attributes until ack
`ifndef EBA_DEFS_VH
`define EBA_DEFS_VH
`define EBA_ADDR_W 30
`define EBA_BE_W 4
`define EBA_ST_IDLE 2'h0
`define EBA_ST_ADDR 2'h1
`define EBA_ST_DATA 2'h2
`define EBA_ST_REL 2'h3
`define EBA_LANE_A30 2
`define EBA_LANE_SIZE 3
`define EBA_LANE_B0 0
`define EBA_LANE_B1 1
`define EBA_SZ_BYTE 2'h0
`define EBA_SZ_HALF 2'h1
`define EBA_SZ_WORD 2'h2
`define EBA_LANES_FIRST_HALF 4'hc
`define EBA_LANES_SECOND_HALF 4'h3
`endif

// File: hw/eba_arb.v
`include "eba_defs.vh"
module eba_arb (
  input wire mclk_i,
  input wire rst_i,
  input wire need_i,
  input wire parked_i,
  input wire bus_grant_n_i,
  input wire bus_busy_n_i,
  input wire own_busy_i,
  input wire tenure_i,
  input wire starting_i,
  output wire qual_o,
  output reg bus_request_n_o
);
  reg qual_q;
  // qualified grant, busy of another master blocks
  wire qual_now = !bus_grant_n_i && (bus_busy_n_i || own_busy_i) && !tenure_i;
  assign qual_o = qual_now || (qual_q && !tenure_i);
  always @(posedge mclk_i) begin
    if (rst_i) begin
      qual_q <= 1'b0;
      bus_request_n_o <= 1'b1;
    end else begin
      qual_q <= qual_now;
      bus_request_n_o <= !(need_i && !parked_i && bus_grant_n_i && !starting_i);
    end
  end
endmodule

// File: hw/eba_lane.v
`include "eba_defs.vh"
module eba_lane (
  input wire port16_i,
  input wire [1:0] low_addr_i,
  input wire [1:0] size_i,
  output reg [`EBA_BE_W-1:0] lane_n_o
);
  always @* begin
    lane_n_o = {`EBA_BE_W{1'b1}};
    if (port16_i) begin
      // 16-bit port lanes, address bit on lane two
      lane_n_o[`EBA_LANE_B0] = (size_i == `EBA_SZ_BYTE) ? low_addr_i[0] : 1'b0;
      lane_n_o[`EBA_LANE_B1] = (size_i == `EBA_SZ_BYTE) ? !low_addr_i[0] : 1'b0;
      lane_n_o[`EBA_LANE_A30] = low_addr_i[1];
      lane_n_o[`EBA_LANE_SIZE] = (size_i != `EBA_SZ_WORD);
    end else begin
      case (size_i)
        `EBA_SZ_BYTE: lane_n_o[low_addr_i] = 1'b0;
        `EBA_SZ_HALF: lane_n_o = low_addr_i[1] ? `EBA_LANES_SECOND_HALF : `EBA_LANES_FIRST_HALF;
        default: lane_n_o = {`EBA_BE_W{1'b0}};
      endcase
    end
  end
endmodule

// File: tb/eba_props.sv
`include "eba_defs.vh"
module eba_props (
  input wire mclk_i,
  input wire rst_i,
  input wire req_ready_o,
  input wire address_ack_n_i,
  input wire bus_request_n_o,
  input wire transfer_start_n_o,
  input wire bus_busy_n_o,
  input wire bus_busy_oe_n_o,
  input wire attr_oe_n_o,
  input wire [`EBA_ADDR_W-1:0] addr_o,
  input wire addr_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_start; !transfer_start_n_o; endsequence
  sequence s_wait; s_start ##1 address_ack_n_i; endsequence
  sequence s_ack; s_start ##1 !address_ack_n_i; endsequence
  property p_pulse; s_start |=> transfer_start_n_o; endproperty
  a_pulse: assert property (p_pulse) else $error("start too long");
  property p_take; s_start |-> $past(req_ready_o); endproperty
  a_take: assert property (p_take) else $error("start without take");
  property p_drop; s_start |-> bus_request_n_o; endproperty
  a_drop: assert property (p_drop) else $error("request kept");
  property p_drive; s_start |-> !attr_oe_n_o && !bus_busy_oe_n_o && !bus_busy_n_o; endproperty
  a_drive: assert property (p_drive) else $error("not driven at start");
  property p_hold; s_wait |=> $stable(addr_o) && !attr_oe_n_o; endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_no_take; s_wait |-> !req_ready_o; endproperty
  a_no_take: assert property (p_no_take) else $error("taken in address phase");
  property p_done; s_ack |=> addr_done_o; endproperty
  a_done: assert property (p_done) else $error("ack not accepted");
  property p_reset;
    disable iff (1'b0) rst_i |=> bus_request_n_o && bus_busy_oe_n_o && attr_oe_n_o;
  endproperty
  a_reset: assert property (p_reset) else $error("not idle at reset");
endmodule
bind eba_master eba_props i_eba_props (.mclk_i, .rst_i, .req_ready_o, .address_ack_n_i,
  .bus_request_n_o, .transfer_start_n_o, .bus_busy_n_o, .bus_busy_oe_n_o, .attr_oe_n_o,
  .addr_o, .addr_done_o);

// File: tb/eba_slave.sv
module eba_slave (
  input wire mclk_i,
  input wire rst_i,
  input wire request_n_i,
  input wire start_n_i,
  input wire wait_i,
  output logic grant_n_o,
  output logic ack_n_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cnt_q;
  logic busy_q;
  always @(posedge mclk_i) begin
    grant_n_o <= request_n_i | rst_i;
    ack_n_o <= 1'b1;
    done_o <= !ack_n_o && !rst_i;
    if (rst_i) begin
      busy_q <= 1'b0;
    end else if (!start_n_i) begin
      // ack from next clock, later when slow
      busy_q <= wait_i;
      cnt_q <= wait_i;
      ack_n_o <= wait_i;
    end else if (busy_q && !cnt_q) begin
      ack_n_o <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= 1'b0;
    end
  end
endmodule

// File: tb/eba_master_tb.sv
module eba_master_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, rst_i = 1, req_valid_i = 0, req_read_i = 0, req_port16_i = 0;
  logic req_stcx_i = 0, parked_i = 0, cancel_n = 1, other = 0, wait_i = 0, int_ack = 0;
  logic [31:0] req_addr_i = 0;
  logic [1:0] req_size_i = 0;
  wire req_ready_o, stcx_fail_o, request_n, busy_n, busy_oe_n, start_n, wr, burst_n;
  wire attr_oe_n, grant_n, ack_n, done, adone;
  wire [29:0] addr;
  wire [3:0] lanes;
  wire busy_w = (busy_oe_n ? 1'b1 : busy_n) & !other;
  int failures = 0, checked = 0, cycles = 0;
  eba_master i_eba_master (.mclk_i, .rst_i, .req_valid_i, .req_ready_o, .req_addr_i,
    .req_read_i, .req_burst_i(1'b0), .req_size_i, .req_port16_i, .req_stcx_i, .parked_i,
    .stcx_fail_o, .bus_grant_n_i(grant_n), .bus_busy_n_i(busy_w),
    .cancel_reservation_n_i(cancel_n), .address_ack_n_i(ack_n), .int_address_ack_i(int_ack),
    .address_retry_n_i(1'b1), .transfer_error_ack_n_i(1'b1), .data_done_i(done),
    .burst_inhibit_n_i(1'b1), .bus_request_n_o(request_n), .bus_busy_n_o(busy_n),
    .bus_busy_oe_n_o(busy_oe_n), .transfer_start_n_o(start_n), .addr_o(addr),
    .write_read_o(wr), .burst_n_o(burst_n), .byte_lane_enable_n_o(lanes),
    .attr_oe_n_o(attr_oe_n), .addr_done_o(adone));
  eba_slave i_eba_slave (.mclk_i, .rst_i, .request_n_i(request_n), .start_n_i(start_n),
    .wait_i, .grant_n_o(grant_n), .ack_n_o(ack_n), .done_o(done));
  initial forever #5 mclk_i = ~mclk_i;
  task summarize;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task go(input logic [31:0] a, input logic rd, p16, st, input logic [1:0] sz);
    int n;
    n = 0;
    @(negedge mclk_i);
    {req_addr_i, req_read_i, req_port16_i, req_stcx_i, req_size_i} = {a, rd, p16, st, sz};
    req_valid_i = 1;
    // Let the combinational ready settle before looking at it
    #1;
    while (req_ready_o !== 1'b1 && n < 40) begin
      @(negedge mclk_i);
      n++;
    end
    @(negedge mclk_i);
    req_valid_i = 0;
    chk(n < 40, 1);
  endtask
  task t_block;
    parked_i = 1;
    req_valid_i = 1;
    repeat (3) @(negedge mclk_i);
    chk(request_n, 1);
    parked_i = 0;
    other = 1;
    repeat (4) @(negedge mclk_i);
    chk(start_n, 1);
    req_valid_i = 0;
    other = 0;
    go(32'h10, 1, 0, 0, 2'h2);
  endtask
  task t_read;
    wait_i = 1;
    go(32'h1234, 1, 0, 0, 2'h2);
    chk({start_n, attr_oe_n, busy_oe_n, busy_w}, 0);
    chk(addr, 30'h48d);
    chk({wr, burst_n, lanes}, 6'h30);
    @(negedge mclk_i);
    int_ack = 1;
    @(negedge mclk_i);
    int_ack = 0;
    chk(adone, 1);
    repeat (10) @(negedge mclk_i);
    chk({busy_oe_n, attr_oe_n}, 3);
    wait_i = 0;
  endtask
  task t_half;
    go(32'h6, 0, 1, 0, 2'h0);
    chk({wr, lanes}, 5'h0e);
  endtask
  task t_cancel;
    cancel_n = 0;
    go(32'h40, 0, 0, 1, 2'h2);
    chk({stcx_fail_o, start_n}, 3);
    cancel_n = 1;
  endtask
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      summarize;
    end
  end
  initial begin
    repeat (8) @(negedge mclk_i);
    rst_i = 0;
    t_block;
    t_read;
    t_half;
    t_cancel;
    repeat (5) @(negedge mclk_i);
    summarize;
  end
endmodule
